// ===== logic/mml_top.sv
// Purpose: Management serial block with manual bit mode and pin based link monitor.
// Assumes: AXI4-Lite register access, 40 MHz clock, synchronous active high reset.
// Notes: The automatic frame engine is not built; its enable bit only gates manual mode.
// What this block does
// - Writing one to the manual select bit hands the management pins to the manual register while the engine enable bit is clear.
// - With the link monitor on, link status follows the sampled receive link pin by itself.
// - The pin link monitor exists only where the instance parameter enables it.
// - The link monitor path is independent of the engine and of manual mode.
// - Two independent manual access channels let two processors reach the pins.
// - Manual register writes set clock and data pins and reads sample the data pin.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`include "mml_defs.svh"
module mml_top #(
  parameter bit HAS_LINK_MONITOR = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire mml_pkg::mml_addr_t awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire mml_pkg::mml_word_t wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire mml_pkg::mml_addr_t araddr,
  input wire logic arvalid,
  output logic arready,
  output mml_pkg::mml_word_t rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic receive_link_input_pin,
  output logic irq
);
  import mml_pkg::*;

  mml_pin_if pins ();
  logic aw_have_q;
  logic w_have_q;
  mml_addr_t aw_addr_q;
  mml_word_t w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  mml_word_t rdata_q;
  logic [1:0] rresp_q;
  logic do_wr;
  logic wr_lane0;
  logic [1:0] ctrl_q;
  logic manual_sel_q;
  mml_man_t man_q [2];
  logic [1:0] owner_q;
  logic [1:0] owner_d;
  logic manual_act;
  mml_man_t drive_sel;
  logic mdc_q;
  logic mdo_q;
  logic oe_q;
  logic link_q;
  logic mon_on;
  logic [1:0] istat_q;
  logic [1:0] imask_q;
  logic [1:0] ist_set;
  logic [1:0] ist_clr;

  // External inputs pass the shared synchroniser before any logic sees them.
  assign pins.raw[MML_PIN_MDI] = mdio_i;
  assign pins.raw[MML_PIN_LINK] = receive_link_input_pin;
  mml_pin_sync #(.W(2)) u_sync (
    .clock(clock),
    .rst(rst),
    .pins(pins.sync)
  );

  // Address and data are caught independently; the write happens once both are held.
  assign awready = !aw_have_q && !bvalid_q;
  assign wready = !w_have_q && !bvalid_q;
  assign do_wr = aw_have_q && w_have_q && !bvalid_q;
  assign wr_lane0 = do_wr && w_strb_q[0];
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (do_wr) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (do_wr) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response one cycle after the write; unmapped offsets answer with an error.
  always_ff @(posedge clock) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= `MML_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= (aw_addr_q <= `MML_IMASK_OFF && aw_addr_q[1:0] == 2'h0) ?
                 `MML_RESP_OKAY : `MML_RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // Control and manual select registers; only byte lane zero carries fields.
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= `MML_CTRL_RESET;
      manual_sel_q <= 1'b0;
    end else if (wr_lane0) begin
      if (aw_addr_q == `MML_CTRL_OFF) begin
        ctrl_q[`MML_CTRL_ENABLE_BIT] <= w_data_q[`MML_CTRL_ENABLE_BIT];
        ctrl_q[`MML_CTRL_MONITOR_BIT] <= w_data_q[`MML_CTRL_MONITOR_BIT] && HAS_LINK_MONITOR;
      end
      if (aw_addr_q == `MML_POLL_OFF) begin
        manual_sel_q <= w_data_q[`MML_POLL_MANUAL_BIT];
      end
    end
  end

  // Each channel keeps its own pin image so two processors never overwrite each other.
  for (genvar c = 0; c < 2; c++) begin : g_chan
    always_ff @(posedge clock) begin
      if (rst) begin
        man_q[c] <= 3'h0;
      end else if (wr_lane0 && aw_addr_q == (`MML_MAN0_OFF + 8'(4 * c))) begin
        man_q[c] <= w_data_q[2:0];
      end
    end
  end

  // Ownership: a claim succeeds only while free, a release only by the holder.
  always_comb begin
    owner_d = owner_q;
    if (wr_lane0 && aw_addr_q == `MML_OWN_OFF) begin
      if (w_data_q[`MML_OWN_RELEASE_BIT] && owner_q[0]) begin
        owner_d = 2'h0;
      end else if (w_data_q[`MML_OWN_RELEASE_BIT + 1] && owner_q[1]) begin
        owner_d = 2'h0;
      end else if (owner_q == 2'h0 && w_data_q[`MML_OWN_CLAIM_BIT]) begin
        owner_d = 2'h1;
      end else if (owner_q == 2'h0 && w_data_q[`MML_OWN_CLAIM_BIT + 1]) begin
        owner_d = 2'h2;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      owner_q <= 2'h0;
    end else begin
      owner_q <= owner_d;
    end
  end

  // Pins belong to the manual port only while selected and the engine is off.
  assign manual_act = manual_sel_q && !ctrl_q[`MML_CTRL_ENABLE_BIT];
  assign drive_sel = owner_q[1] ? man_q[1] : man_q[0];
  always_ff @(posedge clock) begin
    if (rst) begin
      mdc_q <= 1'b0;
      mdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (manual_act) begin
      mdc_q <= drive_sel[`MML_MAN_MDC_BIT];
      mdo_q <= drive_sel[`MML_MAN_MDO_BIT];
      oe_q <= drive_sel[`MML_MAN_OE_BIT];
    end else begin
      mdc_q <= 1'b0;
      mdo_q <= 1'b0;
      oe_q <= 1'b0;
    end
  end
  assign mdc = mdc_q;
  assign mdio_o = mdo_q;
  assign mdio_oe = oe_q;

  // Link monitor follows the pin on its own, whatever the engine or manual mode does.
  assign mon_on = HAS_LINK_MONITOR && ctrl_q[`MML_CTRL_MONITOR_BIT];
  always_ff @(posedge clock) begin
    if (rst) begin
      link_q <= 1'b0;
    end else if (mon_on) begin
      link_q <= pins.level[MML_PIN_LINK];
    end else begin
      link_q <= 1'b0;
    end
  end

  // Sticky link events; a new event beats a clear in the same cycle.
  assign ist_set = {mon_on && link_q && !pins.level[MML_PIN_LINK],
                    mon_on && !link_q && pins.level[MML_PIN_LINK]};
  assign ist_clr = (wr_lane0 && aw_addr_q == `MML_ISTAT_OFF) ? w_data_q[1:0] : 2'h0;
  always_ff @(posedge clock) begin
    if (rst) begin
      istat_q <= 2'h0;
      imask_q <= 2'h0;
    end else begin
      istat_q <= (istat_q & ~ist_clr) | ist_set;
      if (wr_lane0 && aw_addr_q == `MML_IMASK_OFF) begin
        imask_q <= w_data_q[1:0];
      end
    end
  end
  assign irq = |(istat_q & imask_q);

  // Read path: one cycle to data, held until the master takes it.
  assign arready = !rvalid_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `MML_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= `MML_RESP_OKAY;
      case (araddr)
        `MML_CTRL_OFF: rdata_q <= {30'h0, ctrl_q};
        `MML_POLL_OFF: rdata_q <= {31'h0, manual_sel_q};
        `MML_MAN0_OFF: rdata_q <= {28'h0, pins.level[MML_PIN_MDI], man_q[0]};
        `MML_MAN1_OFF: rdata_q <= {28'h0, pins.level[MML_PIN_MDI], man_q[1]};
        `MML_OWN_OFF: rdata_q <= {30'h0, owner_q};
        `MML_LINK_OFF: rdata_q <= {31'h0, link_q};
        `MML_ISTAT_OFF: rdata_q <= {30'h0, istat_q};
        `MML_IMASK_OFF: rdata_q <= {30'h0, imask_q};
        default: begin
          rdata_q <= 32'h00000000;
          rresp_q <= `MML_RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_write_done;
    do_wr ##1 bvalid;
  endsequence

  wr_answer_a: assert property (do_wr |-> s_write_done)
    else $error("write response missing");
  rd_answer_a: assert property (arvalid && arready |=> rvalid ##0 !arready)
    else $error("read answer missing");
  pins_idle_a: assert property (!$past(manual_act) |-> !mdc && !mdio_oe && !mdio_o)
    else $error("pins driven outside manual mode");
  engine_block_a: assert property (ctrl_q[`MML_CTRL_ENABLE_BIT] |=> !mdio_oe)
    else $error("manual drive while engine enabled");
  pin_follow_a: assert property (manual_act && owner_q == 2'h2 |=>
    mdc == $past(man_q[1][`MML_MAN_MDC_BIT]))
    else $error("clock pin does not follow owning channel");
  owner_excl_a: assert property (owner_q != 2'h3)
    else $error("both channels own the pins");
  claim_hold_a: assert property (owner_q == 2'h1 &&
    !(wr_lane0 && aw_addr_q == `MML_OWN_OFF && w_data_q[`MML_OWN_RELEASE_BIT]) |=>
    owner_q == 2'h1)
    else $error("channel zero lost the pins without releasing them");
  link_follow_a: assert property (mon_on && $past(mon_on) &&
    $changed(pins.level[MML_PIN_LINK]) |=> link_q == $past(pins.level[MML_PIN_LINK]))
    else $error("link status does not follow pin");
  no_monitor_a: assert property (!HAS_LINK_MONITOR |-> !link_q && !ctrl_q[1])
    else $error("monitor active on instance without it");
  up_event_a: assert property ($rose(link_q) |-> istat_q[`MML_ISTAT_UP_BIT])
    else $error("link up event not recorded");
endmodule // mml_top

// ===== logic/mml_defs.svh
// Purpose: Register offsets, field positions and reset values of the manual management block.
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register.
// Notes: Definitions only.
`ifndef MML_DEFS_SVH
`define MML_DEFS_SVH
`define MML_CTRL_OFF 8'h00
`define MML_POLL_OFF 8'h04
`define MML_MAN0_OFF 8'h08
`define MML_MAN1_OFF 8'h0C
`define MML_OWN_OFF 8'h10
`define MML_LINK_OFF 8'h14
`define MML_ISTAT_OFF 8'h18
`define MML_IMASK_OFF 8'h1C
`define MML_CTRL_ENABLE_BIT 0
`define MML_CTRL_MONITOR_BIT 1
`define MML_POLL_MANUAL_BIT 0
`define MML_MAN_MDC_BIT 0
`define MML_MAN_MDO_BIT 1
`define MML_MAN_OE_BIT 2
`define MML_MAN_MDI_BIT 3
`define MML_OWN_CLAIM_BIT 0
`define MML_OWN_RELEASE_BIT 2
`define MML_ISTAT_UP_BIT 0
`define MML_ISTAT_DOWN_BIT 1
`define MML_CTRL_RESET 2'h0
`define MML_RESP_OKAY 2'h0
`define MML_RESP_SLVERR 2'h2
`endif

// ===== logic/mml_pkg.sv
// Purpose: Shared types of the manual management block.
// Assumes: Nothing beyond the constants header.
// Notes: Pin index enumeration names the synchronised inputs.
package mml_pkg;
  typedef logic [31:0] mml_word_t;
  typedef logic [7:0] mml_addr_t;
  typedef logic [2:0] mml_man_t;
  typedef enum {MML_PIN_MDI, MML_PIN_LINK} mml_pin_t;
endpackage

// ===== logic/mml_pin_if.sv
// Purpose: Carries raw pin levels to the synchroniser and stable levels back.
// Assumes: Both modports sit on the same clock.
// Notes: Bit 0 is the management data input, bit 1 the receive link input.
interface mml_pin_if;
  logic [1:0] raw;
  logic [1:0] level;
  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface

// ===== logic/mml_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for each external input.
// Assumes: Inputs are asynchronous to clock.
// Notes: A change is accepted once the second and third stages agree.
module mml_pin_sync #(
  parameter int W = 2
) (
  input wire logic clock,
  input wire logic rst,
  mml_pin_if.sync pins
);
  import mml_pkg::*;

  // One independent chain per pin; stage one feeds only stage two.
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    always_ff @(posedge clock) begin
      if (rst) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        lvl_q <= 1'b0;
      end else begin
        s1_q <= pins.raw[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          lvl_q <= s3_q;
        end
      end
    end
    assign pins.level[i] = lvl_q;
  end
endmodule // mml_pin_sync

// ===== testbench/mml_phy_model.sv
// Purpose: Management side of an external PHY for the manual block.
// Assumes: The bench sets link_up; the model shifts a pattern on each clock rise.
// Notes: When nobody drives the data wire the PHY bit shows, so a stale value never passes.
module mml_phy_model (
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic link_up,
  output logic mdio_i,
  output logic receive_link_input_pin,
  output logic phy_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  initial phy_bit = 1'b0;
  // The PHY changes its data bit on every rise of the management clock.
  always @(posedge mdc) phy_bit <= ~phy_bit;
  // Wire level from the block's enable alone; link pin is a steady link indicator.
  assign mdio_i = mdio_oe ? mdio_o : phy_bit;
  assign receive_link_input_pin = link_up;
endmodule // mml_phy_model

// ===== testbench/mml_top_tb.sv
// Purpose: Self-checking bench for the manual management block.
// Assumes: AXI4-Lite master tasks, 40 MHz clock.
// Notes: Expected answers wait in queues until the monitor sees them.
`include "mml_defs.svh"
module mml_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mml_pkg::*;
  logic clock = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, mdc, mdio_i, mdio_o, mdio_oe, irq;
  logic link_pin, phy_bit, link_up = 0;
  logic n_irq;
  mml_addr_t awaddr = 0, araddr = 0;
  mml_word_t wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int failures = 0, checked = 0, cycles = 0;
  integer seed = 86500;
  logic [1:0] v;
  always #12.5 clock = ~clock;
  mml_top i_mml_top (.clock(clock), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .receive_link_input_pin(link_pin), .irq(irq));
  mml_phy_model i_mml_phy_model (.mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .link_up(link_up), .mdio_i(mdio_i), .receive_link_input_pin(link_pin), .phy_bit(phy_bit));
  // A copy built without the monitor sees the same traffic; its bus timing matches the first.
  if (1) begin : g_nomon
    mml_top #(.HAS_LINK_MONITOR(1'b0)) i_mml_top (.clock(clock), .rst(rst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(),
      .bresp(), .bvalid(), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(),
      .rdata(), .rresp(), .rvalid(), .rready(rready), .mdc(), .mdio_i(mdio_i), .mdio_o(),
      .mdio_oe(), .receive_link_input_pin(link_pin), .irq(n_irq));
  end
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input mml_addr_t a, input mml_word_t d, input logic [1:0] r);
    logic ad, dd;
    bq.push_back(r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    ad = 1;
    dd = 1;
    while (ad || dd) begin
      @(posedge clock);
      if (ad && awready) begin
        awvalid <= 0;
        ad = 0;
      end
      if (dd && wready) begin
        wvalid <= 0;
        dd = 0;
      end
    end
    bready <= 1;
    do @(posedge clock); while (!bvalid);
    bready <= 0;
  endtask
  task automatic rd(input mml_addr_t a, input mml_word_t d, input logic [1:0] r);
    rq.push_back({r, d});
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    do @(posedge clock); while (!arready);
    arvalid <= 0;
    rready <= 1;
    do @(posedge clock); while (!rvalid);
    rready <= 0;
  endtask
  // Pins settle one cycle after the register write; three are allowed.
  task automatic pins(input logic [2:0] e);
    repeat (3) @(posedge clock);
    #1 chk({31'h0, mdc, mdio_o, mdio_oe}, {31'h0, e});
  endtask
  // Monitor takes the oldest note whenever an answer is taken.
  always @(posedge clock) begin
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
  end
  // A hang is cut short well past the expected run length.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 0;
    repeat (6) @(posedge clock);
    rd(`MML_CTRL_OFF, 0, `MML_RESP_OKAY);
    rd(`MML_POLL_OFF, 0, `MML_RESP_OKAY);
    rd(8'h20, 0, `MML_RESP_SLVERR);
    wr(8'h20, 0, `MML_RESP_SLVERR);
    wr(`MML_CTRL_OFF, 1, `MML_RESP_OKAY);
    wr(`MML_POLL_OFF, 1, `MML_RESP_OKAY);
    wr(`MML_MAN0_OFF, 7, `MML_RESP_OKAY);
    pins(3'b000);
    wr(`MML_CTRL_OFF, 0, `MML_RESP_OKAY);
    pins(3'b111);
    repeat (4) begin
      v = 2'($random(seed));
      wr(`MML_MAN0_OFF, {29'h0, 1'b1, v}, `MML_RESP_OKAY);
      pins({v[0], v[1], 1'b1});
    end
    // Released data wire: a clock rise makes the PHY bit move, then it is read back.
    wr(`MML_MAN0_OFF, 0, `MML_RESP_OKAY);
    wr(`MML_MAN0_OFF, 1, `MML_RESP_OKAY);
    repeat (8) @(posedge clock);
    rd(`MML_MAN0_OFF, {28'h0, phy_bit, 3'h1}, `MML_RESP_OKAY);
    // Second channel claims, a claim by the first is refused while held.
    wr(`MML_OWN_OFF, 2, `MML_RESP_OKAY);
    rd(`MML_OWN_OFF, 2, `MML_RESP_OKAY);
    wr(`MML_MAN1_OFF, 3, `MML_RESP_OKAY);
    pins(3'b110);
    wr(`MML_OWN_OFF, 1, `MML_RESP_OKAY);
    rd(`MML_OWN_OFF, 2, `MML_RESP_OKAY);
    wr(`MML_OWN_OFF, 8, `MML_RESP_OKAY);
    wr(`MML_OWN_OFF, 1, `MML_RESP_OKAY);
    rd(`MML_OWN_OFF, 1, `MML_RESP_OKAY);
    wr(`MML_OWN_OFF, 2, `MML_RESP_OKAY);
    rd(`MML_OWN_OFF, 1, `MML_RESP_OKAY);
    // Link monitor runs beside manual mode and raises events.
    wr(`MML_IMASK_OFF, 3, `MML_RESP_OKAY);
    wr(`MML_CTRL_OFF, 2, `MML_RESP_OKAY);
    link_up <= 1;
    repeat (10) @(posedge clock);
    rd(`MML_LINK_OFF, 1, `MML_RESP_OKAY);
    rd(`MML_ISTAT_OFF, 1, `MML_RESP_OKAY);
    #1 chk({33'h0, irq}, 34'h1);
    chk({33'h0, n_irq}, 34'h0);
    pins(3'b100);
    wr(`MML_ISTAT_OFF, 1, `MML_RESP_OKAY);
    rd(`MML_ISTAT_OFF, 0, `MML_RESP_OKAY);
    link_up <= 0;
    repeat (10) @(posedge clock);
    rd(`MML_ISTAT_OFF, 2, `MML_RESP_OKAY);
    wr(`MML_IMASK_OFF, 1, `MML_RESP_OKAY);
    #1 chk({33'h0, irq}, 34'h0);
    end_of_test();
  end
endmodule // mml_top_tb
